// [core/iist_consts.vh]
// Constants for the input transition interrupt status tracker.
// Assumes a 25 MHz hclk and a word-wide AHB-Lite register map.
`ifndef IIST_CONSTS_VH
`define IIST_CONSTS_VH

// Register indices; the byte address is four times the index.
`define IIST_IDX_CHANGED   8'h33
`define IIST_IDX_EVENTS    8'h34
`define IIST_IDX_LAST_SCAN 8'h37
`define IIST_IDX_MAX_SCAN  8'h38
`define IIST_IDX_MASK      8'h40
`define IIST_IDX_COMPARE   8'h41
`define IIST_IDX_PRESET    8'h42
`define IIST_IDX_CONFIG    8'h43
`define IIST_IDX_STATUS    8'h44
`define IIST_IDX_IRQ_MASK  8'h45
`define IIST_IDX_CONTROL   8'h46

// Fault and event bits of the status and interrupt-mask registers.
`define IIST_ST_OVERLAP    0
`define IIST_ST_NOT_LOCAL  1
`define IIST_ST_ROUTINE_OV 2
`define IIST_ST_NO_CMD     3
`define IIST_ST_INTERRUPT  4
`define IIST_ST_WIDTH      5

// Config register fields.
`define IIST_CFG_CMD_BIT   0

// Control register bits (self-clearing strobes).
`define IIST_CTL_ROUTINE_DONE 0

`define IIST_PRESET_MAX    16'h7fff

// Scan time tick: 1 ms at 25 MHz.
`define IIST_TICK_NS       1000000
`define IIST_CLK_NS        40
`define IIST_TICK_CYCLES   (`IIST_TICK_NS / `IIST_CLK_NS)

`endif

// [core/iist_edge_detect.v]
// Per-bit qualified transition detector for the monitored input word.
// Assumes the input word is synchronous to hclk.
`timescale 1ns/1ps
`default_nettype none
module iist_edge_detect #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input  wire             hclk,
  input  wire             hresetn,
  // Input word and its qualifiers
  input  wire [WIDTH-1:0] in_word,
  input  wire [WIDTH-1:0] bit_mask,
  input  wire [WIDTH-1:0] compare_val,
  // Qualified transitions this cycle
  output wire [WIDTH-1:0] hit
);
  reg [WIDTH-1:0] prev_r;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_r <= {WIDTH{1'b0}};
    end else begin
      prev_r <= in_word;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // Compare one picks rising edges, zero picks falling edges.
      assign hit[i] = bit_mask[i] & (prev_r[i] != in_word[i]) &
                      (in_word[i] == compare_val[i]);
    end
  endgenerate
endmodule
`default_nettype wire

// [core/iist_tick.v]
// Divider giving a one-cycle enable pulse every COUNT clocks.
// Assumes a single free-running hclk.
`timescale 1ns/1ps
`default_nettype none
module iist_tick #(
  parameter COUNT = 25000
) (
  // Clock and reset
  input  wire hclk,
  input  wire hresetn,
  // One-cycle enable
  output reg  tick
);
  reg [31:0] cnt_r;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 32'h0000_0000;
      tick  <= 1'b0;
    end else if (cnt_r >= COUNT - 1) begin
      cnt_r <= 32'h0000_0000;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h0000_0001;
      tick  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [core/iist_top.v]
// Input transition interrupt status tracker with an AHB-Lite register slave.
// Assumes inputs synchronous to hclk, single word transfers, and that the
// routine signals its own end through the control register.
`timescale 1ns/1ps
`default_nettype none
`include "iist_consts.vh"

module iist_top #(
  parameter WIDTH      = 16,
  parameter TICK_COUNT = `IIST_TICK_CYCLES
) (
  // Clock and reset
  input  wire             hclk,
  input  wire             hresetn,
  // AHB-Lite slave
  input  wire             hsel,
  input  wire [31:0]      haddr,
  input  wire [1:0]       htrans,
  input  wire             hwrite,
  input  wire [2:0]       hsize,
  input  wire [31:0]      hwdata,
  input  wire             hready,
  output reg  [31:0]      hrdata,
  output reg              hreadyout,
  output reg              hresp,
  // Monitored input word and its presence
  input  wire [WIDTH-1:0] in_word,
  input  wire             word_local,
  input  wire             module_present,
  // Interrupt request to the routine and its level interrupt
  output reg              input_transition_interrupt,
  output reg              irq
);
  localparam [WIDTH-1:0] ZERO_W = {WIDTH{1'b0}};

  // Software registers.
  reg [WIDTH-1:0]           mask_r;
  reg [WIDTH-1:0]           compare_r;
  reg [15:0]                preset_r;
  reg                       cmd_present_r;
  reg [`IIST_ST_WIDTH-1:0]  irq_mask_r;
  // Hardware state.
  reg [WIDTH-1:0]           changed_r;
  reg [WIDTH-1:0]           pending_r;
  reg [15:0]                events_r;
  reg [15:0]                last_scan_r;
  reg [15:0]                max_scan_r;
  reg [`IIST_ST_WIDTH-1:0]  status_r;
  reg                       running_r;
  // Bus data phase.
  reg                       dp_write_r;
  reg                       dp_valid_r;
  reg [7:0]                 dp_idx_r;

  wire [WIDTH-1:0] hit;
  wire             tick;

  iist_edge_detect #(
    .WIDTH       (WIDTH)
  ) u_edge (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .in_word     (in_word),
    .bit_mask    (mask_r),
    .compare_val (compare_r),
    .hit         (hit)
  );

  iist_tick #(
    .COUNT   (TICK_COUNT)
  ) u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick)
  );

  wire addr_ok = hsel & hready & htrans[1];
  wire wr_en   = dp_valid_r & dp_write_r;
  wire [15:0] wdata16 = hwdata[15:0];

  wire wr_changed = wr_en & (dp_idx_r == `IIST_IDX_CHANGED);
  wire wr_status  = wr_en & (dp_idx_r == `IIST_IDX_STATUS);
  wire routine_done = wr_en & (dp_idx_r == `IIST_IDX_CONTROL) &
                      hwdata[`IIST_CTL_ROUTINE_DONE];

  // Event counting against the preset.
  wire        any_event  = |hit;
  wire [15:0] events_inc = events_r + 16'h0001;
  wire        fire       = any_event &
                           ((preset_r <= 16'h0001) | (events_inc >= preset_r));
  wire [WIDTH-1:0] fire_bits = pending_r | hit;

  // Bus slave: one wait-free data phase per transfer.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_idx_r   <= 8'h00;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end else begin
      dp_valid_r <= addr_ok;
      dp_write_r <= hwrite;
      if (addr_ok) begin
        dp_idx_r <= haddr[9:2];
      end
    end
  end

  // Read data is registered at the address phase so it stands at the data phase.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok & ~hwrite) begin
      case (haddr[9:2])
        `IIST_IDX_CHANGED:   hrdata <= {16'h0000, changed_r};
        `IIST_IDX_EVENTS:    hrdata <= {16'h0000, events_r};
        `IIST_IDX_LAST_SCAN: hrdata <= {16'h0000, last_scan_r};
        `IIST_IDX_MAX_SCAN:  hrdata <= {16'h0000, max_scan_r};
        `IIST_IDX_MASK:      hrdata <= {16'h0000, mask_r};
        `IIST_IDX_COMPARE:   hrdata <= {16'h0000, compare_r};
        `IIST_IDX_PRESET:    hrdata <= {16'h0000, preset_r};
        `IIST_IDX_CONFIG:    hrdata <= {31'h0000_0000, cmd_present_r};
        `IIST_IDX_STATUS:    hrdata <= {27'h000_0000, status_r};
        `IIST_IDX_IRQ_MASK:  hrdata <= {27'h000_0000, irq_mask_r};
        `IIST_IDX_CONTROL:   hrdata <= {31'h0000_0000, running_r};
        default:             hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Configuration writes.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_r        <= ZERO_W;
      compare_r     <= ZERO_W;
      preset_r      <= 16'h0000;
      cmd_present_r <= 1'b0;
      irq_mask_r    <= {`IIST_ST_WIDTH{1'b0}};
    end else if (wr_en) begin
      case (dp_idx_r)
        `IIST_IDX_MASK:     mask_r    <= wdata16[WIDTH-1:0];
        `IIST_IDX_COMPARE:  compare_r <= wdata16[WIDTH-1:0];
        // Values above the limit saturate rather than wrap.
        `IIST_IDX_PRESET:   preset_r  <= (wdata16 > `IIST_PRESET_MAX) ?
                                         `IIST_PRESET_MAX : wdata16;
        `IIST_IDX_CONFIG:   cmd_present_r <= hwdata[`IIST_CFG_CMD_BIT];
        `IIST_IDX_IRQ_MASK: irq_mask_r <= hwdata[`IIST_ST_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  // Event counter, changed bits and interrupt request.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      events_r                   <= 16'h0000;
      pending_r                  <= ZERO_W;
      changed_r                  <= ZERO_W;
      running_r                  <= 1'b0;
      input_transition_interrupt <= 1'b0;
    end else begin
      input_transition_interrupt <= fire;
      if (fire) begin
        events_r  <= 16'h0000;
        pending_r <= ZERO_W;
      end else if (any_event) begin
        events_r  <= events_inc;
        pending_r <= pending_r | hit;
      end
      // A clearing write loses to bits set in the same cycle.
      if (fire) begin
        changed_r <= (wr_changed ? (changed_r & wdata16[WIDTH-1:0]) : changed_r) |
                     fire_bits;
      end else if (wr_changed) begin
        changed_r <= changed_r & wdata16[WIDTH-1:0];
      end
      if (fire) begin
        running_r <= 1'b1;
      end else if (routine_done) begin
        running_r <= 1'b0;
      end
    end
  end

  // Routine scan time in 1 ms ticks and its maximum.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_scan_r <= 16'h0000;
      max_scan_r  <= 16'h0000;
    end else begin
      if (fire & ~running_r) begin
        last_scan_r <= 16'h0000;
      end else if (running_r & tick & (last_scan_r != 16'hffff)) begin
        last_scan_r <= last_scan_r + 16'h0001;
      end
      if (last_scan_r > max_scan_r) begin
        max_scan_r <= last_scan_r;
      end
    end
  end

  // Sticky status bits; a new event wins over a write-one clear.
  wire [`IIST_ST_WIDTH-1:0] st_set;
  assign st_set[`IIST_ST_OVERLAP]    = fire & |(changed_r & fire_bits);
  assign st_set[`IIST_ST_NOT_LOCAL]  = ~word_local | ~module_present;
  assign st_set[`IIST_ST_ROUTINE_OV] = fire & running_r & |changed_r;
  assign st_set[`IIST_ST_NO_CMD]     = ~cmd_present_r;
  assign st_set[`IIST_ST_INTERRUPT]  = fire;

  wire [`IIST_ST_WIDTH-1:0] st_clr = wr_status ? hwdata[`IIST_ST_WIDTH-1:0] :
                                     {`IIST_ST_WIDTH{1'b0}};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_r <= {`IIST_ST_WIDTH{1'b0}};
      irq      <= 1'b0;
    end else begin
      status_r <= (status_r & ~st_clr) | st_set;
      irq      <= |(((status_r & ~st_clr) | st_set) & irq_mask_r);
    end
  end
endmodule
`default_nettype wire

// [sim/iist_checker.sv]
// Port assertions for the input transition interrupt status tracker.
// Assumes the single hclk domain and the zero-wait register slave of the top.
`timescale 1ns/1ps
`default_nettype none
module iist_checker #(
  parameter WIDTH      = 16,
  parameter TICK_COUNT = 25000
) (
  // Clock and reset
  input wire logic             hclk,
  input wire logic             hresetn,
  // Register bus
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic             hready,
  input wire logic [31:0]      hrdata,
  input wire logic             hreadyout,
  input wire logic             hresp,
  // Input word and interrupt outputs
  input wire logic [WIDTH-1:0] in_word,
  input wire logic             input_transition_interrupt,
  input wire logic             irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire       rd_go = hsel && hready && htrans[1] && !hwrite;
  wire [7:0] idx   = haddr[9:2];
  wire       known = idx inside {8'h33, 8'h34, 8'h37, 8'h38, [8'h40:8'h46]};
  sequence rd_taken;
    rd_go;
  endsequence
  sequence fire_and_count_read;
    input_transition_interrupt ##0 (rd_go && idx == 8'h34);
  endsequence

  okay_resp_a: assert property (hresp == 1'b0) else $error("error response seen");
  no_wait_a: assert property (hreadyout) else $error("wait state seen");
  hold_data_a: assert property (!rd_go |=> $stable(hrdata)) else $error("read data moved");
  upper_zero_a: assert property (rd_taken |=> hrdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  unmapped_zero_a: assert property (rd_go && !known |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  quiet_input_a: assert property (in_word == $past(in_word) |=> !input_transition_interrupt)
    else $error("interrupt without an input change");
  count_clear_a: assert property (fire_and_count_read |=> hrdata[15:0] == 16'h0000)
    else $error("event count not cleared on interrupt");
  reset_quiet_a: assert property ($rose(hresetn) |-> hrdata == 32'h0 && !irq
    && !input_transition_interrupt) else $error("outputs not idle after reset");
endmodule

bind iist_top iist_checker #(.WIDTH(WIDTH), .TICK_COUNT(TICK_COUNT)) chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .in_word(in_word), .input_transition_interrupt(input_transition_interrupt), .irq(irq));
`default_nettype wire

// [sim/iist_input_module.sv]
// Model of the digital input card feeding the tracker.
// Assumes the card presents its terminals synchronously, once per hclk.
`timescale 1ns/1ps
`default_nettype none
module iist_input_module #(
  parameter WIDTH = 16
) (
  // Clock
  input  wire logic             hclk,
  // Terminal values and seating asked for by the bench
  input  wire logic [WIDTH-1:0] next_word,
  input  wire logic             seated,
  // Card pins
  output var  logic [WIDTH-1:0] in_word,
  output var  logic             module_present
);
  initial in_word = '0;
  initial module_present = 1'b1;
  // A one-cycle latch keeps the word free of glitches the tracker could count twice.
  always @(posedge hclk) begin
    in_word        <= next_word;
    module_present <= seated;
  end
endmodule
`default_nettype wire

// [sim/iist_top_bench.sv]
// Self-checking bench for the tracker, driving registers over the bus.
// Assumes the tracker top, its constants header and the input card model.
`timescale 1ns/1ps
`default_nettype none
`include "iist_consts.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED at %0t: got %0h expected %0h", $time, g, e); end end
module iist_top_bench;
  localparam logic [7:0] CHG = `IIST_IDX_CHANGED, EVT = `IIST_IDX_EVENTS;
  localparam logic [7:0] ST = `IIST_IDX_STATUS, CTL = `IIST_IDX_CONTROL;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, word_local = 1, seated = 1;
  logic [31:0] haddr = 0, hwdata = 0, v, m;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [15:0] next_word = 0;
  wire  [31:0] hrdata;
  wire  [15:0] in_word;
  wire         hreadyout, hresp, module_present, fire, irq;
  int          errors = 0, comparisons = 0;
  always #20 hclk = ~hclk;
  iist_input_module card_u (.hclk(hclk), .next_word(next_word), .seated(seated),
    .in_word(in_word), .module_present(module_present));
  iist_top #(.TICK_COUNT(10)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .in_word(in_word), .word_local(word_local), .module_present(module_present),
    .input_transition_interrupt(fire), .irq(irq));
  task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= {22'h0, i, 2'b00};
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    hsel <= 0; htrans <= 2'h0; hwdata <= d;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    xfer(1, i, d, v);
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] e);
    xfer(0, i, 0, v);
    `CHK(v, e)
  endtask
  task automatic put(input logic [15:0] w);
    @(posedge hclk);
    next_word <= w;
  endtask
  task automatic ev(input logic [15:0] w, input logic [31:0] e);
    put(w);
    repeat (3) @(posedge hclk);
    rd(EVT, e);
  endtask
  task automatic results;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge hclk);
    errors++;
    results;
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1;
    rd(CHG, 0); rd(EVT, 0); rd(`IIST_IDX_LAST_SCAN, 0); rd(`IIST_IDX_MAX_SCAN, 0);
    rd(8'h3f, 0);
    wr(`IIST_IDX_PRESET, 32'hffff); rd(`IIST_IDX_PRESET, 32'h7fff);
    $display("test reset_and_map done");
    wr(`IIST_IDX_CONFIG, 1); wr(ST, 32'h1f); wr(`IIST_IDX_MASK, 1);
    wr(`IIST_IDX_COMPARE, 1); wr(`IIST_IDX_PRESET, 3); wr(EVT, 32'h1234);
    ev(16'h0002, 0);
    ev(16'h0003, 1); ev(16'h0002, 1);
    ev(16'h0003, 2); ev(16'h0002, 2);
    ev(16'h0003, 0); rd(CHG, 1);
    $display("test event_counting done");
    wr(ST, 32'h1f); wr(`IIST_IDX_COMPARE, 0); wr(`IIST_IDX_PRESET, 0);
    ev(16'h0002, 0); rd(ST, 32'h15);
    rd(CTL, 1); rd(CHG, 1);
    wr(CHG, 0); rd(CHG, 0); wr(CTL, 1); rd(CTL, 0);
    $display("test overlap done");
    wr(ST, 32'h1f); wr(`IIST_IDX_IRQ_MASK, 32'h02);
    @(posedge hclk) word_local <= 0;
    repeat (3) @(posedge hclk);
    `CHK(irq, 1'b1)
    wr(`IIST_IDX_IRQ_MASK, 0); repeat (2) @(posedge hclk); `CHK(irq, 1'b0)
    @(posedge hclk) begin word_local <= 1; seated <= 0; end
    repeat (2) @(posedge hclk);
    wr(ST, 32'h1f); rd(ST, 32'h02);
    @(posedge hclk) seated <= 1;
    repeat (2) @(posedge hclk);
    wr(ST, 32'h1f); rd(ST, 0); wr(`IIST_IDX_CONFIG, 0);
    put(16'h0003); ev(16'h0002, 0); rd(ST, 32'h18);
    wr(`IIST_IDX_CONFIG, 1); wr(CHG, 0); wr(CTL, 1); wr(ST, 32'h1f);
    $display("test faults_and_irq done");
    wr(`IIST_IDX_PRESET, 1); put(16'h0003); put(16'h0002);
    @(posedge hclk);
    @(negedge hclk);
    @(negedge hclk) `CHK(fire, 1'b1)
    @(negedge hclk) `CHK(fire, 1'b0)
    rd(EVT, 0);
    repeat (300) @(posedge hclk);
    wr(CTL, 1); xfer(0, `IIST_IDX_LAST_SCAN, 0, m);
    `CHK(m >= 30 && m <= 32, 1'b1)
    rd(`IIST_IDX_MAX_SCAN, m); wr(CHG, 0);
    put(16'h0003); put(16'h0002); repeat (20) @(posedge hclk); wr(CTL, 1);
    xfer(0, `IIST_IDX_LAST_SCAN, 0, v); `CHK(v < m, 1'b1)
    rd(`IIST_IDX_MAX_SCAN, m);
    $display("test scan_time done");
    results;
  end
endmodule
`default_nettype wire
